// ### rtl/crcg_pkg.sv
// crcg_pkg: constants shared by the checksum generator and its fifo
// assumes a single 100 MHz core clock and an 8-bit byte stream
package crcg_pkg;

  // =========================================================
  // polynomials and seeds
  localparam logic [15:0] CRCG_POLY16  = 16'h1021;
  localparam logic [31:0] CRCG_POLY32  = 32'h04C1_1DB7;
  localparam logic [31:0] CRCG_SEED    = 32'hFFFF_FFFF;
  localparam logic [31:0] CRCG_MASK16  = 32'h0000_FFFF;

  // =========================================================
  // data path and flash geometry
  localparam int          CRCG_BYTE_W  = 8;
  localparam int          CRCG_FIFO_D  = 16;
  localparam int          CRCG_ADDR_W  = 18;
  localparam logic [17:0] CRCG_FL_LAST = 18'h3_FFFF;
  localparam logic [17:0] CRCG_FL_FIRST = 18'h0_0000;

  // =========================================================
  // flash scan states
  typedef enum logic [1:0] {
    CRCG_SC_IDLE = 2'b00,
    CRCG_SC_REQ  = 2'b01,
    CRCG_SC_WAIT = 2'b10,
    CRCG_SC_LAST = 2'b11
  } crcg_scan_t;

endpackage

// ### rtl/crcg_fifo.sv
// crcg_fifo: synchronous valid/ready fifo with flush
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module crcg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // =========================================================
  // status and read port
  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // storage write
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge core_clk) begin
    if (!rst_b || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + PW'(1);
      if (pop)  rd_ptr <= rd_ptr + PW'(1);
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // while full only a pop or a flush may move the level
  chk_fifo_no_overrun: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !in_ready |=> count == $past(count) - (PW+1)'($past(pop)) || $past(flush))
    else $error("fifo level changed while full without a pop");

endmodule // crcg_fifo

`default_nettype wire

// ### rtl/crcg_gen.sv
// crcg_gen: crc-16 / crc-32 generator and checker over three sources
// assumes synchronous inputs, one outstanding flash read at a time
//
// Overview of operation
// (R1) mode (16 or 32 bit) is taken from cfg_crc32 when crc_clear pulses
// (R2) 16-bit mode divides by x^16+x^12+x^5+1, value 0x1021
// (R3) 32-bit mode divides by the ethernet polynomial 0x04C11DB7
// (R4) checksum output width follows the mode; upper half reads zero in 16-bit
// (R5) every byte the dma channel hands over advances the checksum
// (R6) flash scan reads whole flash or a chosen range by itself
// (R7) each cpu byte write is taken while cpu_ready is high and advances the checksum
// (R8) user reruns calculation on received data; mismatch means data error
// (R9) zero_ok rises when the running remainder is zero
`timescale 1ns/1ps
`default_nettype none

module crcg_gen (
  input  wire logic                          core_clk,
  input  wire logic                          rst_b,
  input  wire logic                          cfg_crc32,
  input  wire logic                          crc_clear,
  input  wire logic                          crc_hold,
  input  wire logic                          cpu_wr,
  input  wire logic [crcg_pkg::CRCG_BYTE_W-1:0] cpu_data,
  output logic                               cpu_ready,
  input  wire logic                          dma_valid,
  input  wire logic [crcg_pkg::CRCG_BYTE_W-1:0] dma_data,
  output logic                               dma_ready,
  input  wire logic                          scan_start,
  input  wire logic                          scan_full,
  input  wire logic [crcg_pkg::CRCG_ADDR_W-1:0] scan_lo,
  input  wire logic [crcg_pkg::CRCG_ADDR_W-1:0] scan_hi,
  output logic                               flash_rd_req,
  output logic      [crcg_pkg::CRCG_ADDR_W-1:0] flash_addr,
  input  wire logic                          flash_rd_valid,
  input  wire logic [crcg_pkg::CRCG_BYTE_W-1:0] flash_rd_data,
  output logic                               scan_busy,
  output logic                               scan_done,
  output logic                               mode_crc32,
  output logic      [31:0]                   checksum,
  output logic                               zero_ok
);
  import crcg_pkg::*;

  // =========================================================
  // byte update, msb first, one polynomial chosen by width
  function automatic logic [31:0] crc_byte(input logic [31:0] cur,
                                           input logic [7:0]  din,
                                           input logic        wide);
    logic [31:0] c;
    logic        fb;
    c  = cur;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (wide) begin
        fb = c[31] ^ din[i];
        c  = {c[30:0], 1'b0} ^ (fb ? CRCG_POLY32 : 32'h0000_0000); // [R3]
      end else begin
        fb = c[15] ^ din[i];
        c  = {16'h0000, c[14:0], 1'b0} ^
             (fb ? {16'h0000, CRCG_POLY16} : 32'h0000_0000); // [R2]
      end
    end
    return c;
  endfunction

  // =========================================================
  // source arbitration into the fifo: flash hold, cpu, dma
  logic                   hold_v;
  logic [CRCG_BYTE_W-1:0] hold_data;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic [CRCG_BYTE_W-1:0] fifo_out_data;
  wire                    sel_cpu = ~hold_v & cpu_wr;
  wire                    sel_dma = ~hold_v & ~cpu_wr & dma_valid;
  wire                    fifo_in_valid = hold_v | sel_cpu | sel_dma;
  wire [CRCG_BYTE_W-1:0]  fifo_in_data  = hold_v  ? hold_data :
                                          sel_cpu ? cpu_data  : dma_data;
  wire                    hold_push = hold_v & fifo_in_ready;

  assign cpu_ready = fifo_in_ready & ~hold_v;            // [R7]
  assign dma_ready = fifo_in_ready & ~hold_v & ~cpu_wr;  // [R5]

  crcg_fifo #(
    .WIDTH (CRCG_BYTE_W),
    .DEPTH (CRCG_FIFO_D)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .flush     (crc_clear),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (~crc_hold),
    .out_data  (fifo_out_data)
  );

  // =========================================================
  // flash scan engine
  crcg_scan_t             scan_st;
  crcg_scan_t             next_scan_st;
  logic [CRCG_ADDR_W-1:0] scan_ptr;
  logic [CRCG_ADDR_W-1:0] scan_end;
  wire                    at_end = (scan_ptr == scan_end);
  wire [CRCG_ADDR_W-1:0]  start_lo = scan_full ? CRCG_FL_FIRST : scan_lo;
  wire [CRCG_ADDR_W-1:0]  start_hi = scan_full ? CRCG_FL_LAST  : scan_hi;

  assign flash_rd_req = (scan_st == CRCG_SC_REQ) & ~hold_v; // [R6]
  assign flash_addr   = scan_ptr;
  assign scan_busy    = (scan_st != CRCG_SC_IDLE);

  // next state of the scan
  always_comb begin
    next_scan_st = scan_st;
    case (scan_st)
      CRCG_SC_IDLE: begin
        if (scan_start && !crc_clear) next_scan_st = CRCG_SC_REQ;
      end
      CRCG_SC_REQ: begin
        if (!hold_v) next_scan_st = CRCG_SC_WAIT;
      end
      CRCG_SC_WAIT: begin
        if (flash_rd_valid) begin
          next_scan_st = at_end ? CRCG_SC_LAST : CRCG_SC_REQ;
        end
      end
      CRCG_SC_LAST: begin
        if (!hold_v) next_scan_st = CRCG_SC_IDLE;
      end
      default: next_scan_st = CRCG_SC_IDLE;
    endcase
    if (crc_clear) next_scan_st = CRCG_SC_IDLE;
  end

  // scan state, address pointer and range end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      scan_st  <= CRCG_SC_IDLE;
      scan_ptr <= '0;
      scan_end <= '0;
    end else begin
      scan_st <= next_scan_st;
      if (scan_st == CRCG_SC_IDLE && scan_start) begin
        scan_ptr <= start_lo; // [R6]
        scan_end <= start_hi;
      end else if (scan_st == CRCG_SC_WAIT && flash_rd_valid && !at_end) begin
        scan_ptr <= scan_ptr + CRCG_ADDR_W'(1);
      end
    end
  end

  // one-cycle done pulse when the last byte leaves the hold register
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      scan_done <= 1'b0;
    end else begin
      scan_done <= (scan_st == CRCG_SC_LAST) & ~hold_v & ~crc_clear;
    end
  end

  // flash read data waits here until the fifo takes it
  always_ff @(posedge core_clk) begin
    if (!rst_b || crc_clear) begin
      hold_v    <= 1'b0;
      hold_data <= '0;
    end else if (scan_st == CRCG_SC_WAIT && flash_rd_valid) begin
      hold_v    <= 1'b1;
      hold_data <= flash_rd_data;
    end else if (hold_push) begin
      hold_v    <= 1'b0;
    end
  end

  // =========================================================
  // checksum register and zero remainder detection
  logic [31:0] crc;
  wire         fire     = fifo_out_valid & ~crc_hold;
  wire [31:0]  next_crc = crc_byte(crc, fifo_out_data, mode_crc32);
  wire [31:0]  next_vis = mode_crc32 ? next_crc : (next_crc & CRCG_MASK16);
  wire [31:0]  seed_vis = cfg_crc32  ? CRCG_SEED : (CRCG_SEED & CRCG_MASK16);

  assign checksum = mode_crc32 ? crc : (crc & CRCG_MASK16); // [R4]

  // mode latches only on clear, so it cannot change mid block
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_crc32 <= 1'b0;
    end else if (crc_clear) begin
      mode_crc32 <= cfg_crc32; // [R1]
    end
  end

  // each consumed byte advances the remainder
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      crc     <= CRCG_SEED & CRCG_MASK16;
      zero_ok <= 1'b0;
    end else if (crc_clear) begin
      crc     <= seed_vis;
      zero_ok <= 1'b0;
    end else if (fire) begin
      crc     <= next_vis;                // [R5] [R7]
      zero_ok <= (next_vis == 32'h0000_0000); // [R9]
    end
  end

  // =========================================================
  // checks
  sequence s_scan_begin;
    scan_st == CRCG_SC_IDLE && scan_start && !crc_clear;
  endsequence
  sequence s_scan_first_req;
    ##[1:2] flash_rd_req && flash_addr == $past(start_lo);
  endsequence
  sequence s_leave_last;
    scan_st == CRCG_SC_LAST && !hold_v && !crc_clear;
  endsequence
  sequence s_done_pulse;
    scan_done && !scan_busy ##1 !scan_done;
  endsequence
  sequence s_cpu_into_empty;
    cpu_wr && cpu_ready && !fifo_out_valid && !crc_clear;
  endsequence

  chk_mode_latch_clear: assert property ( // [R1]
    @(posedge core_clk) disable iff (!rst_b)
    crc_clear |=> mode_crc32 == $past(cfg_crc32) && checksum[15:0] == 16'hFFFF)
    else $error("mode or seed not taken at clear");

  chk_mode_holds: assert property ( // [R1]
    @(posedge core_clk) disable iff (!rst_b)
    !crc_clear |=> $stable(mode_crc32))
    else $error("mode changed without a clear");

  chk_poly16_step: assert property ( // [R2]
    @(posedge core_clk) disable iff (!rst_b)
    fire && !crc_clear && !mode_crc32 && crc == 32'h0000_0000 &&
    fifo_out_data == 8'h01 |=> checksum == 32'h0000_1021)
    else $error("crc-16 step value wrong");

  chk_poly32_step: assert property ( // [R3]
    @(posedge core_clk) disable iff (!rst_b)
    fire && !crc_clear && mode_crc32 && crc == 32'h0000_0000 &&
    fifo_out_data == 8'h01 |=> checksum == 32'h04C1_1DB7)
    else $error("crc-32 step value wrong");

  chk_width_follows: assert property ( // [R4]
    @(posedge core_clk) disable iff (!rst_b)
    !mode_crc32 |-> checksum[31:16] == 16'h0000)
    else $error("upper checksum half not zero in 16-bit mode");

  // result stays put until a byte is consumed or a clear comes
  chk_result_stands: assert property ( // [R4] [R9]
    @(posedge core_clk) disable iff (!rst_b)
    !fire && !crc_clear |=> $stable(checksum) && $stable(zero_ok))
    else $error("checksum moved without a consumed byte");

  chk_dma_byte_taken: assert property ( // [R5]
    @(posedge core_clk) disable iff (!rst_b)
    dma_valid && dma_ready |-> fifo_in_ready && fifo_in_data == dma_data)
    else $error("dma byte not pushed");

  chk_scan_first_read: assert property ( // [R6]
    @(posedge core_clk) disable iff (!rst_b)
    s_scan_begin |-> s_scan_first_req)
    else $error("flash scan did not start at range low");

  chk_scan_in_range: assert property ( // [R6]
    @(posedge core_clk) disable iff (!rst_b)
    flash_rd_req |-> flash_addr != scan_end ||
                     !($past(at_end) && $past(flash_rd_valid)))
    else $error("flash read past range end");

  // only one read may be open towards the flash
  chk_one_read: assert property ( // [R6]
    @(posedge core_clk) disable iff (!rst_b)
    flash_rd_req && !crc_clear |=> !flash_rd_req)
    else $error("second flash read before the answer");

  // once a scan runs, the pointer only steps up by one
  chk_addr_ascends: assert property ( // [R6]
    @(posedge core_clk) disable iff (!rst_b)
    $changed(flash_addr) && $past(scan_st) != CRCG_SC_IDLE |->
      flash_addr == $past(flash_addr) + CRCG_ADDR_W'(1))
    else $error("flash address did not ascend by one");

  chk_done_pulse: assert property ( // [R6]
    @(posedge core_clk) disable iff (!rst_b)
    s_leave_last |=> s_done_pulse)
    else $error("scan end not flagged by a single done pulse");

  chk_clear_aborts: assert property ( // [R6] [R9]
    @(posedge core_clk) disable iff (!rst_b)
    crc_clear |=> !scan_busy && !scan_done && !zero_ok)
    else $error("clear did not abort scan and flag");

  chk_cpu_byte_taken: assert property ( // [R7]
    @(posedge core_clk) disable iff (!rst_b)
    cpu_wr && cpu_ready |-> fifo_in_ready && fifo_in_data == cpu_data)
    else $error("cpu byte not pushed");

  chk_full_refuses: assert property ( // [R5] [R7]
    @(posedge core_clk) disable iff (!rst_b)
    !fifo_in_ready |-> !cpu_ready && !dma_ready)
    else $error("source accepted while fifo full");

  // a byte into an idle path is consumed in the cycle after it is written
  chk_cpu_byte_fires: assert property ( // [R7]
    @(posedge core_clk) disable iff (!rst_b)
    s_cpu_into_empty ##1 !crc_hold |-> fire)
    else $error("cpu byte not consumed after one cycle");

  chk_zero_flag_ties: assert property ( // [R9]
    @(posedge core_clk) disable iff (!rst_b)
    $rose(zero_ok) |-> checksum == 32'h0000_0000 && $past(fire))
    else $error("zero flag without zero remainder");

endmodule // crcg_gen

`default_nettype wire

// ### verification/crcg_flash_model.sv
// crcg_flash_model: flash that answers one byte read at a time
// assumes one-cycle read requests on core_clk, one outstanding
`timescale 1ns/1ps
`default_nettype none

module crcg_flash_model (
  input  wire logic        core_clk,
  input  wire logic        rd_req,
  input  wire logic [17:0] addr,
  output logic             rd_valid,
  output logic      [7:0]  rd_data
);
  // ==========================================================
  // read answer after 1 to 4 cycles
  logic [17:0] a_q;
  int          wait_n = -1;
  initial rd_valid = 1'b0;
  initial rd_data = 8'h00;
  // data bus toggles when idle so no stale byte is seen
  always @(posedge core_clk) begin
    if (!rd_req && wait_n == 0) begin
      rd_valid <= 1'b1; // one answer per request
      rd_data  <= a_q[7:0] ^ a_q[17:10];
    end else begin
      rd_valid <= 1'b0;
      rd_data  <= ~rd_data;
    end
    if (rd_req) begin
      a_q    <= addr;
      wait_n <= $urandom_range(3);
    end else if (wait_n >= 0) begin
      wait_n <= wait_n - 1;
    end
  end
endmodule // crcg_flash_model
`default_nettype wire

// ### verification/tb_crc_generator_checker.sv
// tb_crc_generator_checker: random and corner tests of crcg_gen
// assumes crcg_pkg and crcg_flash_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_crc_generator_checker;
  import crcg_pkg::*;
  // ==========================================================
  // signals
  logic        core_clk, rst_b, cfg_crc32, crc_clear, crc_hold;
  logic        cpu_wr, dma_valid, scan_start, scan_full;
  logic [7:0]  cpu_data, dma_data;
  logic [17:0] scan_lo, scan_hi, lo, hi, next_a;
  wire         cpu_ready, dma_ready, flash_rd_req, flash_rd_valid;
  wire         scan_busy, scan_done, mode_crc32, zero_ok;
  wire  [17:0] flash_addr;
  wire  [7:0]  flash_rd_data;
  wire  [31:0] checksum;
  logic [31:0] exp, s;
  logic        wide;
  int          fails, cmp_count, n;

  crcg_gen dut (.core_clk(core_clk), .rst_b(rst_b),
    .cfg_crc32(cfg_crc32), .crc_clear(crc_clear), .crc_hold(crc_hold),
    .cpu_wr(cpu_wr), .cpu_data(cpu_data), .cpu_ready(cpu_ready),
    .dma_valid(dma_valid), .dma_data(dma_data), .dma_ready(dma_ready),
    .scan_start(scan_start), .scan_full(scan_full), .scan_lo(scan_lo),
    .scan_hi(scan_hi), .flash_rd_req(flash_rd_req),
    .flash_addr(flash_addr), .flash_rd_valid(flash_rd_valid),
    .flash_rd_data(flash_rd_data), .scan_busy(scan_busy),
    .scan_done(scan_done), .mode_crc32(mode_crc32),
    .checksum(checksum), .zero_ok(zero_ok));
  crcg_flash_model flash (.core_clk(core_clk), .rd_req(flash_rd_req),
    .addr(flash_addr), .rd_valid(flash_rd_valid), .rd_data(flash_rd_data));

  // ==========================================================
  // reference checksum, msb first, seed all ones
  function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] d,
                                           logic w);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = d[i] ^ (w ? c[31] : c[15]);
      c  = c << 1;
      if (fb) c = c ^ (w ? CRCG_POLY32 : {16'h0000, CRCG_POLY16});
    end
    return w ? c : c & CRCG_MASK16;
  endfunction

  // ==========================================================
  // checks and verdict
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, want);
    end
  endtask

  // ==========================================================
  // byte source, held until taken; caller lowers it with idle
  task automatic put(logic [7:0] b, logic dma);
    int k;
    k = 0;
    cpu_data  = b;
    dma_data  = b;
    cpu_wr    = !dma;
    dma_valid = dma;
    do begin
      @(posedge core_clk);
      k++;
    end while (!(dma ? dma_ready : cpu_ready) && k < 100);
    if (k >= 100) begin
      fails++;
      end_of_test();
    end
    exp = crc_byte(exp, b, wide);
    @(negedge core_clk);
  endtask
  task automatic idle();
    cpu_wr    = 1'b0;
    dma_valid = 1'b0;
  endtask
  task automatic settle();
    repeat (20) @(negedge core_clk);
  endtask
  task automatic clr(logic w);
    crc_clear = 1'b1;
    cfg_crc32 = w;
    @(negedge core_clk);
    crc_clear = 1'b0;
    @(negedge core_clk);
    wide = w;
    exp  = w ? CRCG_SEED : CRCG_SEED & CRCG_MASK16;
    chk(mode_crc32, w);
    chk(checksum, exp);
  endtask

  // flash reads ascend from the low bound
  always @(posedge core_clk) begin
    if (flash_rd_req === 1'b1) begin
      chk(flash_addr, next_a);
      next_a <= next_a + 18'h0_0001;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================
  // main sequence
  initial begin
    {rst_b, cfg_crc32, crc_clear, crc_hold, cpu_wr, dma_valid} = '0;
    {scan_start, scan_full, cpu_data, dma_data} = '0;
    {scan_lo, scan_hi, next_a, exp, wide} = '0;
    void'($urandom(32'hf203));
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    chk(checksum, 32'h0000_FFFF);
    // random stream from cpu and dma, then appended checksum
    for (int w = 0; w < 2; w++) begin
      clr(w[0]);
      n = 1 + $urandom_range(19);
      repeat (n) put($urandom_range(255), $urandom_range(1));
      idle();
      settle();
      chk(checksum, exp);
      s = exp;
      for (int k = w * 2 + 1; k >= 0; k--) put(s[8 * k +: 8], 1'b1);
      idle();
      settle();
      chk(zero_ok, 1);
      chk(checksum, 0);
      // one set bit from a zero remainder leaves the polynomial
      put(8'h01, 1'b0);
      idle();
      settle();
      chk(checksum, w ? CRCG_POLY32 : {16'h0000, CRCG_POLY16});
      chk(zero_ok, 0);
    end
    // fifo filled while drain is stalled
    clr(1'b1);
    crc_hold = 1'b1;
    repeat (16) put($urandom_range(255), 1'b0);
    chk(cpu_ready, 0);
    idle();
    crc_hold = 1'b0;
    settle();
    chk(checksum, exp);
    // flash range scan
    clr(1'b0);
    lo         = $urandom_range(18'h3_FFF0);
    hi         = lo + $urandom_range(8);
    next_a     = lo;
    scan_lo    = lo;
    scan_hi    = hi;
    scan_start = 1'b1;
    @(negedge core_clk);
    scan_start = 1'b0;
    chk(scan_busy, 1);
    for (logic [17:0] a = lo; a <= hi; a++) begin
      exp = crc_byte(exp, a[7:0] ^ a[17:10], 1'b0);
    end
    n = 0;
    while (scan_done !== 1'b1 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 500) fails++;
    settle();
    chk(checksum, exp);
    // whole-flash scan starts at address zero, cut short by a clear
    next_a     = 18'h0_0000;
    scan_full  = 1'b1;
    scan_start = 1'b1;
    @(negedge core_clk);
    scan_start = 1'b0;
    chk(flash_addr, 18'h0_0000);
    repeat (30) @(negedge core_clk);
    chk(scan_busy, 1);
    clr(1'b1);
    chk(scan_busy, 0);
    end_of_test();
  end
endmodule // tb_crc_generator_checker
`default_nettype wire
